// >>> flash_link_pkg.sv
// constants and carrier types for the two-wire flash programming register set
// assumes every user names items as flash_link_pkg::name
package flash_link_pkg;
    // link register addresses
    localparam logic [7:0] ADDR_PROGRAM_CONTROL = 8'h02;
    localparam logic [7:0] ADDR_PROGRAM_DATA = 8'hB4;
    localparam logic [7:0] ADDR_BANK_SELECT = 8'hC6;
    localparam logic [7:0] ADDR_REVISION = 8'hFE;
    // system register pages
    localparam logic [7:0] PAGE_REVISION = 8'h0F;
    localparam logic [7:0] PAGE_BANK_SELECT = 8'h01;
    // reset values
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] RESET_LINK_ADDRESS = 8'h00;
    // unlock sequence values
    localparam logic [7:0] UNLOCK_FIRST = 8'h02;
    localparam logic [7:0] UNLOCK_SECOND = 8'h01;
    // flash command codes
    localparam logic [7:0] CMD_BLOCK_READ = 8'h06;
    localparam logic [7:0] CMD_BLOCK_WRITE = 8'h07;
    localparam logic [7:0] CMD_PAGE_ERASE = 8'h08;
    localparam logic [7:0] CMD_DEVICE_ERASE = 8'h03;
    // bank select field
    localparam int BANK_BIT = 0;
    // link instruction codes, sent least significant bit first
    localparam logic [1:0] INS_DATA_READ = 2'h0;
    localparam logic [1:0] INS_DATA_WRITE = 2'h1;
    localparam logic [1:0] INS_ADDR_READ = 2'h2;
    localparam logic [1:0] INS_ADDR_WRITE = 2'h3;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [2:0] LAST_INS_BIT = 3'h1;

    // unlock progress
    typedef enum logic [1:0] {
        LOCKED = 2'b00,
        GOT_FIRST = 2'b01,
        UNLOCKED = 2'b11
    } unlock_e;

    // link frame progress
    typedef enum logic [1:0] {
        LINK_IDLE = 2'b00,
        LINK_INS = 2'b01,
        LINK_SHIFT_IN = 2'b11,
        LINK_SHIFT_OUT = 2'b10
    } link_e;

    // request toward the flash sequencer
    typedef struct packed {
        logic cmd_strobe;
        logic byte_strobe;
        logic [7:0] value;
        logic upper_bank_pair_bit;
    } flash_req_s;
endpackage : flash_link_pkg

// >>> two_wire_flash_program_regs.sv
// two-wire debug link slave with the flash programming register set
// assumes link_clk and link_data_in come from pins; flash sequencer and core on mclk
//
// Behaviour
// - a read-only 8-bit revision register sits at link 0xFE and at system 0xFE page 0x0F.
// - an 8-bit control register at link address 0x02 resets to zero and gates programming.
// - programming is enabled only after 0x02 then 0x01 are written to the control register.
// - once enabled, the device stays halted until a system reset.
// - an 8-bit data port at link address 0xB4, reset zero, carries commands, addresses, data.
// - the data port takes codes 0x06 read, 0x07 write, 0x08 page erase, 0x03 device erase.
// - the bank select register is reachable only over the link, never by on-chip software.
// - bank select sits at system 0xC6 page 0x01, reached by address then data commands.
// - bank bit 0 clear maps 0x0000-0xFFFF to banks 0-1, set to banks 2-3, reset zero.
// - bank select bits 7:1 read as zero and ignore writes.
// - system registers are reached by writing the address register then a data read or write.
// - the address register picks the data register, 0x02 control and 0xB4 data port.
`timescale 1ns/100ps
module two_wire_flash_program_regs #(
    parameter logic [7:0] REVISION = 8'h5A // arbitrary value
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic link_clk,
    input wire logic link_data_in,
    output logic link_data_out,
    output logic link_data_oe,
    input wire logic [7:0] sys_addr,
    input wire logic [7:0] sys_page,
    output logic [7:0] sys_rdata,
    output flash_link_pkg::flash_req_s flash_req,
    input wire logic flash_cmd_done,
    input wire logic flash_load_valid,
    input wire logic [7:0] flash_load_data,
    output logic programming_enabled,
    output logic core_halt
);
    logic [1:0] clk_sync;
    logic [1:0] din_sync;
    logic clk_prev;
    flash_link_pkg::link_e link_state;
    flash_link_pkg::link_e next_link_state;
    flash_link_pkg::unlock_e unlock_state;
    logic [1:0] ins;
    logic [2:0] bit_count;
    logic [7:0] shift;
    logic [7:0] link_address_select;
    logic [7:0] program_control;
    logic [7:0] program_data_port;
    logic upper_bank_pair_bit;
    logic arg_phase;

    // two-stage synchronisers, first stage read only by the second
    always_ff @(posedge mclk) begin
        if (reset) begin
            clk_sync <= 2'h0;
            din_sync <= 2'h0;
            clk_prev <= 1'b0;
        end else begin
            clk_sync <= {clk_sync[0], link_clk};
            din_sync <= {din_sync[0], link_data_in};
            clk_prev <= clk_sync[1];
        end
    end

    wire rise = clk_sync[1] & ~clk_prev;
    wire din = din_sync[1];
    wire [7:0] in_byte = {din, shift[7:1]};
    wire [1:0] ins_full = {din, ins[1]};
    wire last_bit = bit_count == flash_link_pkg::LAST_BIT;
    wire last_ins = bit_count == flash_link_pkg::LAST_INS_BIT;

    // frame decode on each link clock rise
    wire ins_done = rise & (link_state == flash_link_pkg::LINK_INS) & last_ins;
    wire in_done = rise & (link_state == flash_link_pkg::LINK_SHIFT_IN) & last_bit;
    wire addr_wr = in_done & (ins == flash_link_pkg::INS_ADDR_WRITE);
    wire data_wr = in_done & (ins == flash_link_pkg::INS_DATA_WRITE);
    wire start_read = ins_done & ~ins_full[0]; // data or address read
    wire is_out_ins = ins_full == flash_link_pkg::INS_DATA_READ
        || ins_full == flash_link_pkg::INS_ADDR_READ;

    // data register selected by the address register
    wire sel_ctrl = link_address_select == flash_link_pkg::ADDR_PROGRAM_CONTROL;
    wire sel_data = link_address_select == flash_link_pkg::ADDR_PROGRAM_DATA;
    wire sel_bank = link_address_select == flash_link_pkg::ADDR_BANK_SELECT;
    wire sel_rev = link_address_select == flash_link_pkg::ADDR_REVISION;
    wire wr_ctrl = data_wr & sel_ctrl;
    wire wr_data = data_wr & sel_data;
    wire wr_bank = data_wr & sel_bank;

    // read mux, bank bits 7:1 read as zero
    wire [7:0] bank_read = {7'h00, upper_bank_pair_bit};
    wire [7:0] data_read_value = sel_ctrl ? program_control
        : sel_data ? program_data_port
        : sel_bank ? bank_read
        : sel_rev ? REVISION
        : flash_link_pkg::RESET_BYTE;
    wire [7:0] read_value = (ins_full == flash_link_pkg::INS_ADDR_READ)
        ? link_address_select : data_read_value;

    // flash command recognition
    wire cmd_valid = in_byte == flash_link_pkg::CMD_BLOCK_READ
        || in_byte == flash_link_pkg::CMD_BLOCK_WRITE
        || in_byte == flash_link_pkg::CMD_PAGE_ERASE
        || in_byte == flash_link_pkg::CMD_DEVICE_ERASE;
    wire unlocked = unlock_state == flash_link_pkg::UNLOCKED;
    wire cmd_take = wr_data & unlocked & ~arg_phase & cmd_valid;
    wire byte_take = wr_data & unlocked & arg_phase;

    // next frame state
    always_comb begin
        next_link_state = link_state;
        case (link_state)
            flash_link_pkg::LINK_IDLE: begin
                if (rise && !din) begin
                    next_link_state = flash_link_pkg::LINK_INS;
                end
            end
            flash_link_pkg::LINK_INS: begin
                if (ins_done) begin
                    next_link_state = is_out_ins ? flash_link_pkg::LINK_SHIFT_OUT
                        : flash_link_pkg::LINK_SHIFT_IN;
                end
            end
            flash_link_pkg::LINK_SHIFT_IN: begin
                if (in_done) begin
                    next_link_state = flash_link_pkg::LINK_IDLE;
                end
            end
            flash_link_pkg::LINK_SHIFT_OUT: begin
                if (rise && last_bit) begin
                    next_link_state = flash_link_pkg::LINK_IDLE;
                end
            end
            default: begin
                next_link_state = flash_link_pkg::LINK_IDLE;
            end
        endcase
    end

    // frame shifter and counters
    always_ff @(posedge mclk) begin
        if (reset) begin
            link_state <= flash_link_pkg::LINK_IDLE;
            bit_count <= 3'h0;
            ins <= 2'h0;
            shift <= flash_link_pkg::RESET_BYTE;
        end else begin
            link_state <= next_link_state;
            if (rise) begin
                if (link_state == flash_link_pkg::LINK_IDLE || ins_done) begin
                    bit_count <= 3'h0;
                end else begin
                    bit_count <= bit_count + 3'h1;
                end
                if (link_state == flash_link_pkg::LINK_INS) begin
                    ins <= ins_full;
                end
                if (start_read) begin
                    shift <= read_value;
                end else if (link_state == flash_link_pkg::LINK_SHIFT_OUT) begin
                    shift <= {1'b0, shift[7:1]};
                end else if (link_state == flash_link_pkg::LINK_SHIFT_IN) begin
                    shift <= in_byte;
                end
            end
        end
    end

    // data line drive during read frames
    always_ff @(posedge mclk) begin
        if (reset) begin
            link_data_oe <= 1'b0;
            link_data_out <= 1'b0;
        end else begin
            link_data_oe <= next_link_state == flash_link_pkg::LINK_SHIFT_OUT;
            if (start_read) begin
                link_data_out <= read_value[0];
            end else if (rise && link_state == flash_link_pkg::LINK_SHIFT_OUT) begin
                link_data_out <= shift[1];
            end
        end
    end

    // link-visible registers
    always_ff @(posedge mclk) begin
        if (reset) begin
            link_address_select <= flash_link_pkg::RESET_LINK_ADDRESS;
            program_control <= flash_link_pkg::RESET_BYTE;
            program_data_port <= flash_link_pkg::RESET_BYTE;
            upper_bank_pair_bit <= 1'b0;
        end else begin
            if (addr_wr) begin
                link_address_select <= in_byte;
            end
            if (wr_ctrl) begin
                program_control <= in_byte;
            end
            if (wr_data) begin
                program_data_port <= in_byte;
            end else if (flash_load_valid) begin
                program_data_port <= flash_load_data;
            end
            if (wr_bank) begin
                upper_bank_pair_bit <= in_byte[flash_link_pkg::BANK_BIT];
            end
        end
    end

    // unlock sequence, left only by reset
    always_ff @(posedge mclk) begin
        if (reset) begin
            unlock_state <= flash_link_pkg::LOCKED;
        end else if (wr_ctrl) begin
            case (unlock_state)
                flash_link_pkg::LOCKED: begin
                    if (in_byte == flash_link_pkg::UNLOCK_FIRST) begin
                        unlock_state <= flash_link_pkg::GOT_FIRST;
                    end
                end
                flash_link_pkg::GOT_FIRST: begin
                    if (in_byte == flash_link_pkg::UNLOCK_SECOND) begin
                        unlock_state <= flash_link_pkg::UNLOCKED;
                    end else if (in_byte != flash_link_pkg::UNLOCK_FIRST) begin
                        unlock_state <= flash_link_pkg::LOCKED;
                    end
                end
                flash_link_pkg::UNLOCKED: begin
                    unlock_state <= flash_link_pkg::UNLOCKED;
                end
                default: begin
                    unlock_state <= flash_link_pkg::LOCKED;
                end
            endcase
        end
    end

    // command then argument bytes toward the flash sequencer
    always_ff @(posedge mclk) begin
        if (reset) begin
            arg_phase <= 1'b0;
            flash_req <= '0;
        end else begin
            if (cmd_take) begin
                arg_phase <= 1'b1;
            end else if (flash_cmd_done) begin
                arg_phase <= 1'b0;
            end
            flash_req.cmd_strobe <= cmd_take;
            flash_req.byte_strobe <= byte_take;
            if (cmd_take || byte_take) begin
                flash_req.value <= in_byte;
            end
            flash_req.upper_bank_pair_bit <= upper_bank_pair_bit;
        end
    end

    // software view: revision only, bank select deliberately absent
    wire sys_rev_hit = sys_addr == flash_link_pkg::ADDR_REVISION
        && sys_page == flash_link_pkg::PAGE_REVISION;
    always_ff @(posedge mclk) begin
        if (reset) begin
            sys_rdata <= flash_link_pkg::RESET_BYTE;
            programming_enabled <= 1'b0;
            core_halt <= 1'b0;
        end else begin
            sys_rdata <= sys_rev_hit ? REVISION : flash_link_pkg::RESET_BYTE;
            programming_enabled <= unlocked;
            core_halt <= unlocked;
        end
    end
endmodule : two_wire_flash_program_regs

// >>> flash_link_monitor.sv
// port assertions for the two-wire flash programming register set
// assumes one mclk domain with synchronous active-high reset
`timescale 1ns/100ps
module flash_link_monitor #(
    parameter logic [7:0] REVISION = 8'h5A // arbitrary value
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic link_clk,
    input wire logic link_data_in,
    input wire logic link_data_out,
    input wire logic link_data_oe,
    input wire logic [7:0] sys_addr,
    input wire logic [7:0] sys_page,
    input wire logic [7:0] sys_rdata,
    input wire flash_link_pkg::flash_req_s flash_req,
    input wire logic flash_cmd_done,
    input wire logic flash_load_valid,
    input wire logic [7:0] flash_load_data,
    input wire logic programming_enabled,
    input wire logic core_halt
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    // software port, unlock state, flash strobes and link data drive
    property p_soft_rev;
        sys_addr == 8'hFE && sys_page == 8'h0F |=> sys_rdata == REVISION;
    endproperty
    a_soft_rev: assert property (p_soft_rev) else $error("revision missing");
    property p_soft_hide;
        !(sys_addr == 8'hFE && sys_page == 8'h0F) |=> sys_rdata == 8'h00;
    endproperty
    a_soft_hide: assert property (p_soft_hide) else $error("software sees a register");
    property p_release; $fell(reset) |-> !programming_enabled && flash_req == '0; endproperty
    a_release: assert property (p_release) else $error("not reset");
    property p_halt; core_halt == programming_enabled; endproperty
    a_halt: assert property (p_halt) else $error("halt differs");
    property p_sticky; programming_enabled |=> programming_enabled; endproperty
    a_sticky: assert property (p_sticky) else $error("enable dropped");
    property p_quiet;
        !programming_enabled |-> !flash_req.cmd_strobe && !flash_req.byte_strobe;
    endproperty
    a_quiet: assert property (p_quiet) else $error("strobe while locked");
    property p_code;
        flash_req.cmd_strobe |-> flash_req.value inside {8'h06, 8'h07, 8'h08, 8'h03};
    endproperty
    a_code: assert property (p_code) else $error("bad command");
    property p_pulse; flash_req.cmd_strobe |=> !flash_req.cmd_strobe; endproperty
    a_pulse: assert property (p_pulse) else $error("long strobe");
    property p_oe; $rose(link_data_oe) |-> link_data_oe [*8]; endproperty
    a_oe: assert property (p_oe) else $error("short drive");
    c_cmd: cover property (flash_req.cmd_strobe);
    c_byte: cover property (flash_req.byte_strobe);
    c_unlock: cover property ($rose(programming_enabled));
endmodule : flash_link_monitor
bind two_wire_flash_program_regs flash_link_monitor #(.REVISION(REVISION)) u_mon (
    .mclk(mclk), .reset(reset), .link_clk(link_clk), .link_data_in(link_data_in),
    .link_data_out(link_data_out), .link_data_oe(link_data_oe), .sys_addr(sys_addr),
    .sys_page(sys_page), .sys_rdata(sys_rdata), .flash_req(flash_req),
    .flash_cmd_done(flash_cmd_done), .flash_load_valid(flash_load_valid),
    .flash_load_data(flash_load_data), .programming_enabled(programming_enabled),
    .core_halt(core_halt));

// >>> link_host_model.sv
// host adapter model: link frames paced by mclk
// assumes the bench pulls the data wire high when released
`timescale 1ns/100ps
module link_host_model (
    input wire logic mclk,
    input wire logic data_wire,
    output logic link_clk = 1'b0,
    output logic host_oe = 1'b0,
    output logic host_out = 1'b1
);
    // one bit: data set while low, sampled at the end of low, then rise
    task automatic slot(input logic drv, input logic b, output logic s);
        @(posedge mclk);
        link_clk <= 1'b0;
        host_oe <= drv;
        host_out <= b;
        repeat (4) @(posedge mclk);
        s = data_wire;
        link_clk <= 1'b1;
        repeat (3) @(posedge mclk);
    endtask : slot
    // start bit, instruction, data, lsb first; clock stands low after
    task automatic frame(input logic [1:0] ins, input logic [7:0] wd, output logic [7:0] rd);
        logic s;
        slot(1'b1, 1'b0, s);
        for (int i = 0; i < 2; i++) slot(1'b1, ins[i], s);
        for (int i = 0; i < 8; i++) begin
            slot(ins[0], wd[i], s); // even codes read, so release the line
            rd[i] = s;
        end
        @(posedge mclk);
        link_clk <= 1'b0;
        host_oe <= 1'b0;
        repeat (8) @(posedge mclk);
    endtask : frame
    // register access: address write, then data read or write
    task automatic reg_acc(input logic wr, input logic [7:0] a, input logic [7:0] d,
        output logic [7:0] q);
        frame(flash_link_pkg::INS_ADDR_WRITE, a, q);
        frame(wr ? flash_link_pkg::INS_DATA_WRITE : flash_link_pkg::INS_DATA_READ, d, q);
    endtask : reg_acc
endmodule : link_host_model

// >>> tb.sv
// self-checking bench for the two-wire flash programming register set
// assumes the host model and the bound port monitor
`timescale 1ns/100ps
module tb;
    localparam logic [7:0] REV = 8'h3C; // arbitrary value
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic flash_cmd_done = 1'b0;
    logic flash_load_valid = 1'b0;
    logic link_clk, host_oe, host_out, data_wire, link_data_out, link_data_oe;
    logic programming_enabled, core_halt;
    logic [7:0] sys_addr = 8'h00, sys_page = 8'h00, flash_load_data = 8'h00, sys_rdata, r, c0, b0;
    logic [7:0] n_cmd = 8'h00, n_byte = 8'h00;
    flash_link_pkg::flash_req_s flash_req;
    int fails = 0, tests_run = 0, cyc = 0;
    assign data_wire = link_data_oe ? link_data_out : (host_oe ? host_out : 1'b1);
    two_wire_flash_program_regs #(.REVISION(REV)) i_two_wire_flash_program_regs (
        .mclk(mclk), .reset(reset), .link_clk(link_clk), .link_data_in(data_wire),
        .link_data_out(link_data_out), .link_data_oe(link_data_oe), .sys_addr(sys_addr),
        .sys_page(sys_page), .sys_rdata(sys_rdata), .flash_req(flash_req),
        .flash_cmd_done(flash_cmd_done), .flash_load_valid(flash_load_valid),
        .flash_load_data(flash_load_data), .programming_enabled(programming_enabled),
        .core_halt(core_halt));
    link_host_model u_host (.mclk(mclk), .data_wire(data_wire), .link_clk(link_clk),
        .host_oe(host_oe), .host_out(host_out));
    initial begin
        forever #20 mclk = ~mclk;
    end
    // strobe counters and watchdog
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        n_cmd <= n_cmd + {7'h00, flash_req.cmd_strobe === 1'b1};
        n_byte <= n_byte + {7'h00, flash_req.byte_strobe === 1'b1};
        if (cyc == 20000) begin
            fails = fails + 1;
            report_and_stop();
        end
    end
    // compare, register and software port helpers
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        u_host.reg_acc(1'b0, a, 8'h00, r);
        check(r, e);
    endtask : rd_chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_host.reg_acc(1'b1, a, d, r);
    endtask : wr
    task automatic sys_chk(input logic [7:0] a, input logic [7:0] p, input logic [7:0] e);
        @(posedge mclk);
        sys_addr <= a;
        sys_page <= p;
        repeat (2) @(posedge mclk);
        check(sys_rdata, e);
    endtask : sys_chk
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop
    // scenarios
    task automatic t_reset_rev();
        rd_chk(8'h02, 8'h00);
        rd_chk(8'hB4, 8'h00);
        rd_chk(8'hC6, 8'h00);
        u_host.frame(flash_link_pkg::INS_ADDR_READ, 8'h00, r);
        check(r, 8'hC6);
        wr(8'hFE, 8'hA5);
        rd_chk(8'hFE, REV);
        sys_chk(8'hFE, 8'h0F, REV);
        sys_chk(8'hFE, 8'h01, 8'h00);
        $display("t_reset_rev done");
    endtask : t_reset_rev
    task automatic t_bank();
        wr(8'hC6, 8'hFF);
        rd_chk(8'hC6, 8'h01);
        check({7'h00, flash_req.upper_bank_pair_bit}, 8'h01);
        sys_chk(8'hC6, 8'h01, 8'h00);
        wr(8'hC6, 8'hFE);
        check({7'h00, flash_req.upper_bank_pair_bit}, 8'h00);
        $display("t_bank done");
    endtask : t_bank
    task automatic t_unlock();
        c0 = n_cmd;
        wr(8'hB4, 8'h07);
        check(n_cmd - c0, 8'h00);
        wr(8'h02, 8'h02);
        wr(8'h02, 8'h03);
        wr(8'h02, 8'h01);
        check({7'h00, programming_enabled}, 8'h00);
        wr(8'h02, 8'h02);
        wr(8'h02, 8'h02);
        wr(8'h02, 8'h01);
        check({7'h00, core_halt}, 8'h01);
        rd_chk(8'h02, 8'h01);
        $display("t_unlock done");
    endtask : t_unlock
    task automatic t_cmds();
        logic [7:0] codes [4] = '{8'h06, 8'h07, 8'h08, 8'h03};
        wr(8'hC6, 8'h01);
        check({7'h00, flash_req.upper_bank_pair_bit}, 8'h01);
        for (int i = 0; i < 4; i++) begin
            c0 = n_cmd;
            b0 = n_byte;
            wr(8'hB4, codes[i]);
            check(n_cmd - c0, 8'h01);
            check(flash_req.value, codes[i]);
            wr(8'hB4, 8'h55);
            check(n_byte - b0, 8'h01);
            check(flash_req.value, 8'h55);
            @(posedge mclk);
            flash_cmd_done <= 1'b1;
            @(posedge mclk);
            flash_cmd_done <= 1'b0;
        end
        c0 = n_cmd;
        wr(8'hB4, 8'h55);
        check(n_cmd - c0, 8'h00);
        flash_load_valid <= 1'b1;
        flash_load_data <= 8'hA5;
        @(posedge mclk);
        flash_load_valid <= 1'b0;
        rd_chk(8'hB4, 8'hA5);
        $display("t_cmds done");
    endtask : t_cmds
    task automatic t_exit();
        wr(8'h02, 8'h00);
        check({7'h00, programming_enabled}, 8'h01);
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        repeat (4) @(posedge mclk);
        check({7'h00, programming_enabled}, 8'h00);
        check({7'h00, core_halt}, 8'h00);
        rd_chk(8'hC6, 8'h00);
        $display("t_exit done");
    endtask : t_exit
    initial begin
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        repeat (4) @(posedge mclk);
        t_reset_rev();
        t_bank();
        t_unlock();
        t_cmds();
        t_exit();
        report_and_stop();
    end
endmodule : tb
